// ### rtl/access_ctrl_defines.svh
// Purpose: Constants of the front-panel access controller
// Assumes: 100 MHz system clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef ACCESS_CTRL_DEFINES_SVH
`define ACCESS_CTRL_DEFINES_SVH

// Register offsets on the plain register port
`define REG_CTRL          4'h0
`define REG_STATUS        4'h1
`define REG_SCREEN        4'h2

// Control register fields
`define CTRL_SWRST_BIT    0
`define CTRL_FACTORY_BIT  1
`define CTRL_TGT_LSB      2
`define CTRL_TGT_MSB      3
`define CTRL_STAT_BIT     4

// Timing
`define CLK_PERIOD_NS     10
`define TICK_PERIOD_NS    1_000_000_000
`define DISP_TIMEOUT_S    180
`define INPUT_TIMEOUT_S   60

// Factory passwords, first character in the top byte
`define PW1_DEFAULT       32'h5030_3031
`define PW2_DEFAULT       32'h5030_3032
`define PW3_DEFAULT       32'h4142_4344

// Level status after factory init: level 1 off, 2 off, 3 on
`define LVL_ON_DEFAULT    3'h4

// Character set and masking
`define CHAR_MIN          8'h21
`define CHAR_MAX          8'h7e
`define CHAR_INIT         8'h41
`define CHAR_MASK         8'h2a
`define CHAR_SPACE        8'h20

// Screen numbers
`define SCR_START         7'h7f
`define SCR_PROMPT        7'h0b

`endif

// ### rtl/access_ctrl_pkg.sv
// Purpose: Types of the front-panel access controller
// Assumes: access_ctrl_defines.svh holds the numbers
// Notes:   Levels run 0 (none) to 3 (highest)
package access_ctrl_pkg;

    typedef logic [1:0]      lvl_t;
    typedef logic [3:0][7:0] word_t;

    // Gray codes along start, prompt, browse, edit, locked
    typedef enum logic [2:0] {
        ST_START  = 3'h0,
        ST_PROMPT = 3'h1,
        ST_BROWSE = 3'h3,
        ST_EDIT   = 3'h2,
        ST_LOCKED = 3'h6
    } state_t;

    typedef enum logic [1:0] {
        ED_PWD   = 2'h0,
        ED_MSG   = 2'h1,
        ED_PARAM = 2'h2
    } kind_t;

    typedef struct packed {
        logic up;
        logic down;
        logic left;
        logic right;
        logic ok;
        logic cancel;
    } keys_t;

    typedef struct packed {
        logic [6:0] screen;
        logic       blank;
        logic       edit;
        logic [1:0] cursor;
        word_t      text;
    } disp_t;

endpackage

// ### rtl/sec_timer.sv
// Purpose: Seconds time-out counter, restarted by activity
// Assumes: tick is a one-cycle pulse once a second
// Notes:   expired pulses once when LIMIT seconds pass without restart
`timescale 1ns/1ps
module sec_timer
    import access_ctrl_pkg::*;
#(
    parameter int LIMIT = 60
)(
    input  wire logic clk_sys,  // System clock
    input  wire logic nrst,     // Synchronous reset, active low
    input  wire logic ce,       // Clock enable
    input  wire logic tick,     // One-second pulse
    input  wire logic run,      // Counting allowed
    input  wire logic restart,  // Activity, restarts the count
    output logic      expired   // One-cycle time-out pulse
);
    localparam int W = $clog2(LIMIT + 1);

    logic [W-1:0] cnt_q;

    // Count whole seconds while running, clear on activity
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cnt_q   <= '0;
            expired <= 1'b0;
        end
        else if (ce)
        begin
            expired <= 1'b0;
            if (restart || !run)
                cnt_q <= '0;
            else if (tick)
            begin
                if (cnt_q == W'(LIMIT - 1))
                begin
                    cnt_q   <= '0;
                    expired <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + W'(1);
            end
        end
    end
endmodule

// ### rtl/menu_password_access_ctrl.sv
// Purpose: Menu walker and password guard for the front panel
// Assumes: keypad levels are asynchronous, one key per press
// Notes:   Menu screen number is column times ten plus row
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "access_ctrl_defines.svh"
module menu_password_access_ctrl
    import access_ctrl_pkg::*;
#(
    parameter int        CYCLES_PER_SEC = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
    parameter int        DISP_TO_S      = `DISP_TIMEOUT_S,
    parameter int        INPUT_TO_S     = `INPUT_TIMEOUT_S,
    parameter logic [31:0] SW_VERSION   = 32'h5631_3030  // Arbitrary value
)(
    input  wire logic        clk_sys,   // System clock, 100 MHz
    input  wire logic        nrst,      // Synchronous reset, active low
    input  wire logic        ce,        // Clock enable, freezes all state
    input  wire keys_t       key_pin,   // Raw keypad levels, high = pressed
    input  wire logic [3:0]  addr,      // Register address
    input  wire logic [31:0] wdata,     // Register write data
    input  wire logic        wr,        // Register write strobe
    input  wire logic        rd,        // Register read strobe
    output logic      [31:0] rdata,     // Read data, cycle after rd
    output disp_t            disp,      // Display contents
    output logic             lamp_test, // Indicator lamp test drive
    output lvl_t             level      // Granted level
);
    localparam int TW = $clog2(CYCLES_PER_SEC);

    keys_t        k1_q, k2_q, k3_q;
    keys_t        press;
    logic         any_key;
    logic [TW-1:0] pre_q;
    logic         tick_q;
    logic         disp_exp, inp_exp;
    state_t       state_q;
    kind_t        kind_q;
    logic [1:0]   col_q;
    logic [2:0]   row_q;
    lvl_t         gr_q;
    logic         invalid_q;
    word_t        buf_q;
    logic [1:0]   cur_q;
    word_t        pw_q [1:3];
    logic [3:1]   lvl_on_q;
    word_t        msg_q;
    logic [7:0]   par_q [0:31];
    logic [4:0]   tgt_q;
    logic         swrst, factory;
    lvl_t         base_lvl, match_lvl, tgt_lvl;
    logic         commit;
    logic [6:0]   scr_num;
    logic [4:0]   idx;

    // Level needed to show a screen
    function automatic lvl_t view_lvl(input logic [1:0] c, input logic [2:0] r);
        lvl_t v;
        v = 2'd2;
        if (c == 2'd0)
            v = (r == 3'd0) ? 2'd0 : 2'd1;
        else if (c == 2'd2 && (r == 3'd2 || r == 3'd7))
            v = 2'd3;
        else if (c == 2'd3)
            v = 2'd3;
        return v;
    endfunction

    // Level needed to edit a screen
    function automatic lvl_t edit_lvl(input logic [1:0] c, input logic [2:0] r);
        lvl_t v;
        v = 2'd2;
        if (c == 2'd0 && r == 3'd0)
            v = 2'd3;
        else if (c == 2'd1 && r == 3'd3)
            v = 2'd1;
        else if (view_lvl(c, r) == 2'd3)
            v = 2'd3;
        return v;
    endfunction

    // Step through the printable character set
    function automatic logic [7:0] char_step(input logic [7:0] ch, input logic dn);
        logic [7:0] v;
        if (dn)
            v = (ch <= `CHAR_MIN) ? `CHAR_MAX : ch - 8'd1;
        else
            v = (ch >= `CHAR_MAX) ? `CHAR_MIN : ch + 8'd1;
        return v;
    endfunction

    // Keypad synchroniser and press edge
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            k1_q <= '0;
            k2_q <= '0;
            k3_q <= '0;
        end
        else if (ce)
        begin
            k1_q <= key_pin;
            k2_q <= k1_q;
            k3_q <= k2_q;
        end
    end

    assign press   = k2_q & ~k3_q;
    assign any_key = |press;

    // One-second tick from the system clock
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pre_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (ce)
        begin
            tick_q <= (pre_q == TW'(CYCLES_PER_SEC - 1));
            pre_q  <= (pre_q == TW'(CYCLES_PER_SEC - 1)) ? '0 : pre_q + TW'(1);
        end
    end

    // Display time-out, restarted by any key outside the locked state
    sec_timer #(.LIMIT(DISP_TO_S)) u_disp_to (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .tick    (tick_q),
        .run     (state_q != ST_START),
        .restart (any_key && state_q != ST_LOCKED),
        .expired (disp_exp)
    );

    // Local input time-out while entering data
    sec_timer #(.LIMIT(INPUT_TO_S)) u_input_to (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .tick    (tick_q),
        .run     (state_q == ST_EDIT || state_q == ST_PROMPT),
        .restart (any_key),
        .expired (inp_exp)
    );

    // Decode of stored levels, matching and commit
    always_comb
    begin
        base_lvl = 2'd0;
        if (!lvl_on_q[1])
            base_lvl = lvl_on_q[2] ? 2'd1 : 2'd2;
        match_lvl = 2'd0;
        if (buf_q == pw_q[3])
            match_lvl = 2'd3;
        else if (buf_q == pw_q[2])
            match_lvl = 2'd2;
        else if (buf_q == pw_q[1])
            match_lvl = 2'd1;
        tgt_lvl = tgt_q[1:0];
        swrst   = wr && addr == `REG_CTRL && wdata[`CTRL_SWRST_BIT];
        factory = wr && addr == `REG_CTRL && wdata[`CTRL_FACTORY_BIT];
        commit  = ce && state_q == ST_EDIT && press.ok && !disp_exp && !swrst && !factory;
        idx     = {col_q, row_q};
        scr_num = 7'(col_q) * 7'd10 + 7'(row_q);
    end

    // Menu walker and entry state
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_q   <= ST_START;
            kind_q    <= ED_PWD;
            col_q     <= '0;
            row_q     <= '0;
            gr_q      <= '0;
            invalid_q <= 1'b0;
            buf_q     <= {4{`CHAR_INIT}};
            cur_q     <= '0;
        end
        else if (ce)
        begin
            if (swrst || factory)
            begin
                state_q <= ST_START;
                gr_q    <= '0;
            end
            else if (disp_exp)
            begin
                state_q   <= ST_BROWSE;
                gr_q      <= base_lvl;
                col_q     <= '0;
                row_q     <= '0;
                invalid_q <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    ST_START:
                        if (any_key)
                        begin
                            state_q <= ST_PROMPT;
                            buf_q   <= {4{`CHAR_INIT}};
                            cur_q   <= '0;
                        end
                    ST_PROMPT, ST_EDIT:
                    begin
                        if (press.up || press.down)
                            buf_q[2'd3 - cur_q] <=
                                char_step(buf_q[2'd3 - cur_q], press.down);
                        if (press.left)
                            cur_q <= cur_q - 2'd1;
                        if (press.right)
                            cur_q <= cur_q + 2'd1;
                        if (state_q == ST_PROMPT && press.ok)
                        begin
                            col_q <= '0;
                            row_q <= '0;
                            if (match_lvl != 2'd0)
                            begin
                                gr_q      <= match_lvl;
                                invalid_q <= 1'b0;
                                state_q   <= ST_BROWSE;
                            end
                            else
                            begin
                                gr_q      <= base_lvl;
                                invalid_q <= 1'b1;
                                state_q   <= ST_LOCKED;
                            end
                        end
                        else if (state_q == ST_PROMPT && (press.cancel || inp_exp))
                        begin
                            gr_q      <= base_lvl;
                            invalid_q <= 1'b1;
                            state_q   <= ST_BROWSE;
                            col_q     <= '0;
                            row_q     <= '0;
                        end
                        else if (press.ok || press.cancel || inp_exp)
                            state_q <= ST_BROWSE;
                    end
                    ST_BROWSE:
                        if (lvl_on_q[1] && gr_q == 2'd0)
                        begin
                            if (any_key)
                            begin
                                state_q <= ST_PROMPT;
                                buf_q   <= {4{`CHAR_INIT}};
                                cur_q   <= '0;
                            end
                        end
                        else if (press.ok && gr_q >= edit_lvl(col_q, row_q))
                        begin
                            state_q <= ST_EDIT;
                            cur_q   <= '0;
                            if (col_q == 2'd0 && row_q == 3'd0)
                            begin
                                kind_q <= ED_MSG;
                                buf_q  <= msg_q;
                            end
                            else if (col_q == 2'd1 && row_q == 3'd3)
                            begin
                                kind_q <= ED_PWD;
                                buf_q  <= {4{`CHAR_INIT}};
                            end
                            else
                            begin
                                kind_q <= ED_PARAM;
                                buf_q  <= {par_q[idx], {3{`CHAR_SPACE}}};
                            end
                        end
                        else if (press.cancel)
                        begin
                            if (col_q != 2'd0)
                                col_q <= col_q - 2'd1;
                            else
                                row_q <= '0;
                        end
                        else if (press.left && col_q != 2'd0)
                            col_q <= col_q - 2'd1;
                        else if (press.right && col_q != 2'd3
                                 && gr_q >= view_lvl(col_q + 2'd1, row_q))
                            col_q <= col_q + 2'd1;
                        else if (press.up && row_q != 3'd0
                                 && gr_q >= view_lvl(col_q, row_q - 3'd1))
                            row_q <= row_q - 3'd1;
                        else if (press.down && row_q != 3'd7
                                 && gr_q >= view_lvl(col_q, row_q + 3'd1))
                            row_q <= row_q + 3'd1;
                    ST_LOCKED:
                        state_q <= ST_LOCKED;
                    default:
                        state_q <= ST_START;
                endcase
            end
        end
    end

    // Stored passwords and level status
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            pw_q[1]  <= `PW1_DEFAULT;
            pw_q[2]  <= `PW2_DEFAULT;
            pw_q[3]  <= `PW3_DEFAULT;
            lvl_on_q <= `LVL_ON_DEFAULT;
        end
        else if (ce)
        begin
            if (factory)
            begin
                pw_q[1]  <= `PW1_DEFAULT;
                pw_q[2]  <= `PW2_DEFAULT;
                pw_q[3]  <= `PW3_DEFAULT;
                lvl_on_q <= `LVL_ON_DEFAULT;
            end
            else if (commit && kind_q == ED_PWD && tgt_lvl != 2'd0 && gr_q >= tgt_lvl)
            begin
                pw_q[tgt_lvl]     <= buf_q;
                lvl_on_q[tgt_lvl] <= tgt_q[4];
            end
            if (disp_exp)
                lvl_on_q[3] <= 1'b1;
        end
    end

    // Home message and screen parameters
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            msg_q <= {4{`CHAR_SPACE}};
            for (int i = 0; i < 32; i++)
                par_q[i] <= '0;
        end
        else if (ce && commit)
        begin
            if (kind_q == ED_MSG)
                msg_q <= buf_q;
            else if (kind_q == ED_PARAM)
                par_q[idx] <= buf_q[3];
        end
    end

    // Register port: control writes, status reads
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tgt_q <= '0;
            rdata <= '0;
        end
        else if (ce)
        begin
            if (wr && addr == `REG_CTRL)
                tgt_q <= {wdata[`CTRL_STAT_BIT], 2'b00,
                          wdata[`CTRL_TGT_MSB:`CTRL_TGT_LSB]};
            rdata <= '0;
            if (rd)
            begin
                unique case (addr)
                    `REG_CTRL:   rdata <= {27'h0, tgt_q[4], 2'b00, tgt_q[1:0]};
                    `REG_STATUS: rdata <= {22'h0, state_q, lvl_on_q,
                                           invalid_q, state_q == ST_LOCKED, gr_q};
                    `REG_SCREEN: rdata <= {25'h0, disp.screen};
                    default:     rdata <= '0;
                endcase
            end
        end
    end

    // Display frame and lamp test
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            disp      <= '0;
            lamp_test <= 1'b0;
        end
        else if (ce)
        begin
            disp.blank  <= (state_q == ST_LOCKED);
            disp.edit   <= (state_q == ST_EDIT || state_q == ST_PROMPT);
            disp.cursor <= cur_q;
            lamp_test   <= (state_q == ST_START) ? (lamp_test ^ tick_q) : 1'b0;
            unique case (state_q)
                ST_START:
                begin
                    disp.screen <= `SCR_START;
                    disp.text   <= lamp_test ? {4{8'hff}} : SW_VERSION;
                end
                ST_PROMPT:
                begin
                    disp.screen <= `SCR_PROMPT;
                    disp.text   <= {4{`CHAR_MASK}};
                end
                ST_LOCKED:
                begin
                    disp.screen <= `SCR_PROMPT;
                    disp.text   <= {4{`CHAR_SPACE}};
                end
                default:
                begin
                    disp.screen <= (lvl_on_q[1] && gr_q == 2'd0) ? 7'd0 : scr_num;
                    if (state_q == ST_EDIT && kind_q == ED_PWD)
                        disp.text <= {4{`CHAR_MASK}};
                    else if (state_q == ST_EDIT)
                        disp.text <= buf_q;
                    else if (idx == 5'd0)
                        disp.text <= msg_q;
                    else if (col_q == 2'd1 && row_q == 3'd3)
                        disp.text <= {4{`CHAR_MASK}};
                    else
                        disp.text <= {par_q[idx], {3{`CHAR_SPACE}}};
                end
            endcase
        end
    end

    assign level = gr_q;
endmodule

// ### bench/access_ctrl_checker.sv
// Purpose: Port assertions of the front-panel access controller
// Assumes: ce held high by the bench
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`include "access_ctrl_defines.svh"
module access_ctrl_checker
    import access_ctrl_pkg::*;
(
    input  wire logic        clk_sys,   // System clock
    input  wire logic        nrst,      // Synchronous reset, active low
    input  wire logic        ce,        // Clock enable
    input  wire logic        rd,        // Read strobe
    input  wire logic [31:0] rdata,     // Read data
    input  wire disp_t       disp,      // Display frame
    input  wire logic        lamp_test, // Lamp test drive
    input  wire lvl_t        level      // Granted level
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Bus answer, masking, lamp test, lockout and grant relations
    chk_rdata_idle: assert property (!$past(rd) && $past(ce) |-> rdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
    chk_text_masked: assert property (disp.screen == 7'h0d |->
        disp.text == {4{`CHAR_MASK}}) else $error("password screen not masked");
    chk_lamp_rise: assert property ($rose(lamp_test) |-> disp.screen == `SCR_START)
        else $error("lamp test outside start screen");
    chk_lamp_idle: assert property (disp.screen != `SCR_START &&
        $past(disp.screen) != `SCR_START |-> !lamp_test) else $error("lamp test left on");
    chk_locked_still: assert property (disp.blank && $past(disp.blank) |->
        $stable(disp) && $stable(level)) else $error("change while locked");
    chk_blank_level: assert property (disp.blank |-> level != 2'h3)
        else $error("top level granted while locked");
    chk_edit_shown: assert property (disp.edit |-> !disp.blank)
        else $error("edit while locked");
    chk_level_grant: assert property ($changed(level) && level == 2'h3 |->
        disp.screen == `SCR_PROMPT || $past(disp.screen) == `SCR_PROMPT)
        else $error("top level granted outside prompt");
endmodule

bind menu_password_access_ctrl access_ctrl_checker i_access_ctrl_checker (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .rd(rd), .rdata(rdata),
    .disp(disp), .lamp_test(lamp_test), .level(level));

// ### bench/keypad_model.sv
// Purpose: Operator pressing front-panel keys
// Assumes: one key per press
// Notes:   Held 4 cycles, released 4, above the 1-cycle minimum
`timescale 1ns/1ps
module keypad_model
    import access_ctrl_pkg::*;
(
    input  wire logic clk_sys, // System clock
    output keys_t     key_pin  // Key levels, high = pressed
);
    initial key_pin = '0;

    // One press and release, changed just after an edge
    task automatic press(input keys_t k);
        @(posedge clk_sys);
        key_pin <= k;
        repeat (4) @(posedge clk_sys);
        key_pin <= '0;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

// ### bench/tb.sv
// Purpose: Self-checking bench of the access controller
// Assumes: 10 cycles a second, 3 s display and 2 s input time-out
// Notes:   Keys come from the keypad model, registers from tasks
`timescale 1ns/1ps
`include "access_ctrl_defines.svh"
module tb
    import access_ctrl_pkg::*;
;
    localparam keys_t k_up = 6'h20, k_dn = 6'h10, k_lt = 6'h08;
    localparam keys_t k_rt = 6'h04, k_ok = 6'h02, k_cn = 6'h01;
    keys_t       pw_seq [10] = '{k_rt, k_up, k_rt, k_up, k_up, k_rt, k_up, k_up, k_up, k_ok};
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic [31:0] rv;
    keys_t       key_pin;
    disp_t       disp;
    logic        lamp_test;
    lvl_t        level;
    int          err_total = 0;
    int          cmp_count = 0;

    always #5 clk_sys = ~clk_sys;

    menu_password_access_ctrl #(.CYCLES_PER_SEC(10), .DISP_TO_S(3), .INPUT_TO_S(2))
        i_menu_password_access_ctrl (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .key_pin(key_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .disp(disp), .lamp_test(lamp_test), .level(level));
    keypad_model i_keypad_model (.clk_sys(clk_sys), .key_pin(key_pin));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic keys(input keys_t k, input int n);
        repeat (n) i_keypad_model.press(k);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        test_done();
    end

    // Main sequence: start, lockout, grant, navigation, time-out, edit
    initial
    begin
        idle(20);
        nrst <= 1'b1;
        idle(3);
        chk("start screen", disp.screen, `SCR_START);
        reg_rd(`REG_STATUS);
        chk("reset status", rv & 32'h0000_03ff, 32'h0000_0040);
        reg_rd(4'hf);
        chk("unmapped read", rv, 32'h0000_0000);
        keys(k_ok, 1);
        chk("prompt", disp.screen, `SCR_PROMPT);
        chk("prompt mask", disp.text, {4{`CHAR_MASK}});
        keys(k_ok, 1);
        keys(k_rt, 1);
        chk("locked", {disp.blank, disp.screen}, {1'b1, `SCR_PROMPT});
        chk("locked level", level, 2'h2);
        reg_rd(`REG_STATUS);
        chk("lock invalid", rv[3:2], 2'h3);
        idle(50);
        chk("unlocked", {disp.blank, disp.screen}, 8'h00);
        reg_wr(`REG_CTRL, 32'h0000_0001);
        idle(3);
        chk("sw reset", disp.screen, `SCR_START);
        keys(k_dn, 1);
        foreach (pw_seq[i])
            keys(pw_seq[i], 1);
        chk("granted", level, 2'h3);
        chk("home", disp.screen, 7'h00);
        keys(k_ok, 1);
        chk("message edit", disp.edit, 1'b1);
        keys(k_cn, 1);
        chk("message cancel", disp.edit, 1'b0);
        keys(k_rt, 1);
        keys(k_dn, 3);
        chk("pwd screen", disp.screen, 7'h0d);
        chk("pwd mask", disp.text, {4{`CHAR_MASK}});
        keys(k_rt, 2);
        chk("column three", disp.screen, 7'h21);
        keys(k_lt, 1);
        chk("left", disp.screen, 7'h17);
        keys(k_cn, 3);
        chk("cancel home", disp.screen, 7'h00);
        idle(50);
        chk("time-out level", level, 2'h2);
        // Harmless press re-arms the display time-out before stepping right
        keys(k_lt, 1);
        keys(k_rt, 3);
        chk("right refused", disp.screen, 7'h14);
        keys(k_dn, 2);
        chk("critical refused", disp.screen, 7'h15);
        keys(k_ok, 1);
        chk("edit on", disp.edit, 1'b1);
        keys(k_up, 1);
        keys(k_ok, 1);
        chk("edit commit", {disp.edit, disp.screen}, 8'h15);
        keys(k_ok, 1);
        idle(18);
        chk("input time-out", {disp.edit, disp.screen}, 8'h15);
        reg_wr(`REG_CTRL, 32'h0000_0014);
        idle(10);
        keys(k_rt, 1);
        keys(k_dn, 3);
        keys(k_ok, 1);
        chk("pwd entry mask", disp.text, {4{`CHAR_MASK}});
        keys(k_ok, 1);
        reg_rd(`REG_STATUS);
        chk("pwd status", rv & 32'h0000_007f, 32'h0000_0052);
        idle(50);
        chk("level one on", {level, disp.screen}, 9'h000);
        keys(k_rt, 2);
        chk("prompt again", disp.screen, `SCR_PROMPT);
        keys(k_ok, 1);
        chk("new level one", level, 2'h1);
        test_done();
    end
endmodule
